//--- rtl/msam_defs.vh
// constants for the memory space address map block
// assumes inclusion by msam_top.v only; msam_lane.v does not include it
`ifndef MSAM_DEFS_VH
`define MSAM_DEFS_VH
`define MSAM_RESET_PC 23'h000000
`define MSAM_START_VEC 23'h000002
`define MSAM_IVT_PRI_LO 23'h000004
`define MSAM_IVT_PRI_HI 23'h0000ff
`define MSAM_IVT_ALT_LO 23'h000100
`define MSAM_IVT_ALT_HI 23'h0001ff
`define MSAM_PC_STEP 23'h000002
`define MSAM_SFR_TOP 16'h07ff
`define MSAM_NEAR_TOP 16'h1fff
`define MSAM_RAM_TOP 16'h77ff
`define MSAM_WIN_BIT 15
`define MSAM_PTR_BYTE_STEP 16'h0001
`define MSAM_PTR_WORD_STEP 16'h0002
`define MSAM_SFR_WORDS 1024
`define MSAM_RAM_WORDS 15360
`define MSAM_RAM_BASE 16'h0800
`define MSAM_UPPER_PAD 8'h00
`endif

//--- rtl/msam_lane.v
// byte lane helper: selects read byte and builds write data and strobes
// assumes a 16-bit word path, even byte at the low lane
`timescale 1ns/100ps
module msam_lane (
  input wire [15:0] rd_word,
  input wire rd_a0,
  input wire rd_byte,
  input wire [15:0] wr_data,
  input wire wr_a0,
  input wire wr_byte,
  output wire [15:0] rd_data,
  output wire [15:0] wr_word,
  output wire [1:0] wr_lane
);
  wire [7:0] sel;
  assign sel = rd_a0 ? rd_word[15:8] : rd_word[7:0];
  assign rd_data = rd_byte ? {8'h00, sel} : rd_word;
  assign wr_word = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
  assign wr_lane = wr_byte ? (wr_a0 ? 2'b10 : 2'b01) : 2'b11;
endmodule

//--- rtl/msam_top.v
// memory space address map: program counter stepping, vector decode,
// data address decode, lane control, misalignment trap, pointer update
// assumes the core drives request strobes synchronous to CLOCK
`timescale 1ns/100ps
`include "msam_defs.vh"
module msam_top (
  input wire CLOCK,
  input wire RSTN,
  input wire PC_STEP,
  input wire PC_BACK,
  input wire PC_LOAD,
  input wire [22:0] PC_LOAD_VAL,
  input wire IRQ_TAKE,
  input wire IRQ_ALT,
  input wire [6:0] IRQ_NUM,
  output wire [23:0] PROG_ADDR,
  output wire [22:0] PROG_PC,
  output wire PROG_IN_VEC,
  input wire [23:0] PROG_WORD,
  output wire [15:0] PROG_HALF,
  input wire RD_REQ,
  input wire RD_BYTE,
  input wire RD_DIRECT13,
  input wire RD_DIRECT16,
  input wire [12:0] RD_NEAR_ADDR,
  input wire [15:0] RD_ABS_ADDR,
  input wire [15:0] SOURCE_POINTER_REG,
  input wire RD_POST_INC,
  output reg [15:0] RD_DATA,
  output reg RD_VALID,
  output reg [15:0] SRC_PTR_NEXT,
  output wire [15:0] RD_BYTE_POINTER,
  output wire RD_TO_WINDOW,
  input wire [15:0] WIN_DATA,
  input wire WR_REQ,
  input wire WR_BYTE,
  input wire [15:0] WR_BYTE_POINTER,
  input wire [15:0] WR_DATA,
  output wire SFR_RD_EN,
  output wire [9:0] SFR_RD_IDX,
  input wire [15:0] SFR_RD_DATA,
  input wire SFR_RD_HIT,
  output wire SFR_WR_EN,
  output wire [9:0] SFR_WR_IDX,
  output wire [15:0] SFR_WR_DATA,
  output wire [1:0] SFR_WR_LANE,
  input wire PROGRAM_WINDOW_ENABLE,
  output reg ADDR_ERR_TRAP,
  output reg ADDR_ERR_RD,
  output reg ADDR_ERR_WR,
  input wire WREG_OP,
  input wire WREG_BYTE,
  input wire [15:0] WREG_OLD,
  input wire [15:0] WREG_SRC,
  input wire SIGN_EXTEND_OP,
  input wire ZERO_EXTEND_OP,
  output reg [15:0] WREG_NEW
);
  ////////////////////////////////////////////////////////////////////////
  // program counter
  reg [22:0] pc_r;
  reg [22:0] pc_nxt;
  wire [7:0] vec_off;
  // one program location (two addresses) per vector entry
  assign vec_off = {IRQ_NUM, 1'b0};
  always @* begin
    pc_nxt = pc_r;
    if (IRQ_TAKE) begin
      // primary table after reset slots; alternate table from 0x100
      pc_nxt = (IRQ_ALT ? `MSAM_IVT_ALT_LO : `MSAM_IVT_PRI_LO) +
               {15'h0000, vec_off};
    end else if (PC_LOAD) begin
      pc_nxt = {PC_LOAD_VAL[22:1], 1'b0};
    end else if (PC_STEP) begin
      pc_nxt = pc_r + `MSAM_PC_STEP;
    end else if (PC_BACK) begin
      pc_nxt = pc_r - `MSAM_PC_STEP;
    end
  end
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pc_r <= `MSAM_RESET_PC;
    end else begin
      pc_r <= pc_nxt;
    end
  end
  assign PROG_PC = pc_r;
  assign PROG_ADDR = {1'b0, pc_r};
  // vector region covers reset slots and both tables
  assign PROG_IN_VEC = (pc_r <= `MSAM_IVT_ALT_HI);
  // odd half of a location returns the upper word, top byte empty
  assign PROG_HALF = pc_r[0] ? {`MSAM_UPPER_PAD, PROG_WORD[23:16]}
                             : PROG_WORD[15:0];
  ////////////////////////////////////////////////////////////////////////
  // read address generator
  reg [15:0] rd_ptr;
  always @* begin
    if (RD_DIRECT13) begin
      rd_ptr = {3'b000, RD_NEAR_ADDR};
    end else if (RD_DIRECT16) begin
      rd_ptr = RD_ABS_ADDR;
    end else begin
      rd_ptr = SOURCE_POINTER_REG;
    end
  end
  assign RD_BYTE_POINTER = rd_ptr;
  wire rd_mis;
  wire wr_mis;
  assign rd_mis = RD_REQ && !RD_BYTE && rd_ptr[0];
  assign wr_mis = WR_REQ && !WR_BYTE && WR_BYTE_POINTER[0];
  wire rd_win;
  wire rd_sfr;
  wire rd_ram;
  assign rd_win = rd_ptr[`MSAM_WIN_BIT];
  assign RD_TO_WINDOW = rd_win && PROGRAM_WINDOW_ENABLE;
  assign rd_sfr = !rd_win && (rd_ptr <= `MSAM_SFR_TOP);
  assign rd_ram = !rd_win && !rd_sfr && (rd_ptr <= `MSAM_RAM_TOP);
  ////////////////////////////////////////////////////////////////////////
  // data ram, word organised with two byte lanes
  reg [15:0] ram [0:`MSAM_RAM_WORDS-1];
  wire [15:0] rd_off;
  wire [15:0] wr_off;
  assign rd_off = rd_ptr - `MSAM_RAM_BASE;
  assign wr_off = WR_BYTE_POINTER - `MSAM_RAM_BASE;
  wire [13:0] rd_idx;
  wire [13:0] wr_idx;
  assign rd_idx = rd_off[14:1];
  assign wr_idx = wr_off[14:1];
  wire wr_win;
  wire wr_sfr;
  wire wr_ram;
  wire wr_go;
  assign wr_win = WR_BYTE_POINTER[`MSAM_WIN_BIT];
  assign wr_sfr = !wr_win && (WR_BYTE_POINTER <= `MSAM_SFR_TOP);
  assign wr_ram = !wr_win && !wr_sfr &&
                  (WR_BYTE_POINTER <= `MSAM_RAM_TOP);
  // suppress the store on misalignment, instruction still proceeds
  assign wr_go = WR_REQ && !wr_mis;
  wire [15:0] wr_word;
  wire [1:0] wr_lane;
  wire [15:0] rd_sel;
  reg [15:0] rd_word;
  reg rd_byte_r;
  reg rd_a0_r;
  msam_lane u_lane (
    .rd_word(rd_word),
    .rd_a0(rd_a0_r),
    .rd_byte(rd_byte_r),
    .wr_data(WR_DATA),
    .wr_a0(WR_BYTE_POINTER[0]),
    .wr_byte(WR_BYTE),
    .rd_data(rd_sel),
    .wr_word(wr_word),
    .wr_lane(wr_lane)
  );
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : lane
      always @(posedge CLOCK) begin
        if (wr_go && wr_ram && wr_lane[g]) begin
          ram[wr_idx][g*8+7:g*8] <= wr_word[g*8+7:g*8];
        end
      end
    end
  endgenerate
  assign SFR_WR_EN = wr_go && wr_sfr;
  assign SFR_WR_IDX = WR_BYTE_POINTER[10:1];
  assign SFR_WR_DATA = wr_word;
  assign SFR_WR_LANE = wr_lane;
  assign SFR_RD_EN = RD_REQ && rd_sfr && !rd_mis;
  assign SFR_RD_IDX = rd_ptr[10:1];
  ////////////////////////////////////////////////////////////////////////
  // read side: valid one cycle after request, data two cycles after request
  reg [1:0] rd_src_r;
  reg [15:0] ram_q;
  always @(posedge CLOCK) begin
    ram_q <= ram[rd_idx];
  end
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rd_src_r <= 2'h0;
      rd_byte_r <= 1'b0;
      rd_a0_r <= 1'b0;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_REQ;
      rd_byte_r <= RD_BYTE;
      rd_a0_r <= rd_ptr[0];
      if (rd_ram) begin
        rd_src_r <= 2'h1;
      end else if (RD_TO_WINDOW) begin
        rd_src_r <= 2'h2;
      end else if (rd_sfr) begin
        rd_src_r <= 2'h3;
      end else begin
        rd_src_r <= 2'h0;
      end
    end
  end
  always @* begin
    case (rd_src_r)
      2'h1: rd_word = ram_q;
      2'h2: rd_word = WIN_DATA;
      2'h3: rd_word = SFR_RD_HIT ? SFR_RD_DATA : 16'h0000;
      default: rd_word = 16'h0000;
    endcase
  end
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      RD_DATA <= 16'h0000;
      SRC_PTR_NEXT <= 16'h0000;
    end else begin
      RD_DATA <= rd_sel;
      if (RD_REQ && RD_POST_INC) begin
        SRC_PTR_NEXT <= SOURCE_POINTER_REG + (RD_BYTE ?
          `MSAM_PTR_BYTE_STEP : `MSAM_PTR_WORD_STEP);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // address error trap, raised after the access cycle
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ADDR_ERR_TRAP <= 1'b0;
      ADDR_ERR_RD <= 1'b0;
      ADDR_ERR_WR <= 1'b0;
    end else begin
      ADDR_ERR_TRAP <= rd_mis || wr_mis;
      ADDR_ERR_RD <= rd_mis;
      ADDR_ERR_WR <= wr_mis;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // working register byte load and extends
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      WREG_NEW <= 16'h0000;
    end else if (SIGN_EXTEND_OP) begin
      WREG_NEW <= {{8{WREG_SRC[7]}}, WREG_SRC[7:0]};
    end else if (ZERO_EXTEND_OP) begin
      WREG_NEW <= {8'h00, WREG_SRC[7:0]};
    end else if (WREG_OP) begin
      // byte load keeps the upper byte of the old value
      WREG_NEW <= WREG_BYTE ? {WREG_OLD[15:8], WREG_SRC[7:0]}
                            : WREG_SRC;
    end
  end
endmodule

//--- sim/msam_monitor.sv
// checker for msam_top: program counter, traps, pointers, window, working register
// assumes bind to msam_top, single clock CLOCK, async reset RSTN
`timescale 1ns/100ps
module msam_monitor (
  input wire CLOCK, RSTN, PC_STEP, PC_LOAD, IRQ_TAKE,
  input wire RD_REQ, RD_BYTE, RD_POST_INC, RD_VALID, RD_TO_WINDOW,
  input wire WR_REQ, WR_BYTE, SFR_WR_EN, ADDR_ERR_TRAP, ADDR_ERR_WR,
  input wire PROGRAM_WINDOW_ENABLE, WREG_OP, WREG_BYTE,
  input wire SIGN_EXTEND_OP, ZERO_EXTEND_OP,
  input wire [22:0] PROG_PC,
  input wire [15:0] SOURCE_POINTER_REG, SRC_PTR_NEXT, WR_BYTE_POINTER,
  input wire [15:0] RD_BYTE_POINTER, WREG_OLD, WREG_NEW
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  wire mis_wr = WR_REQ && !WR_BYTE && WR_BYTE_POINTER[0];
  sequence mis_wr_s; mis_wr; endsequence
  sequence trap_wr_s; ADDR_ERR_TRAP && ADDR_ERR_WR; endsequence
  pc_even_a: assert property (!PROG_PC[0])
    else $error("odd program counter");
  pc_step_a: assert property (PC_STEP && !PC_LOAD && !IRQ_TAKE |=>
    PROG_PC == $past(PROG_PC) + 23'h2) else $error("bad pc step");
  wr_drop_a: assert property (mis_wr_s |-> !SFR_WR_EN ##1 trap_wr_s)
    else $error("misaligned write not trapped");
  trap_cause_a: assert property (ADDR_ERR_WR |->
    $past(mis_wr)) else $error("bad trap");
  rd_answer_a: assert property (RD_REQ |=> RD_VALID)
    else $error("read not answered");
  post_inc_a: assert property (RD_REQ && RD_POST_INC |=> SRC_PTR_NEXT ==
    $past(SOURCE_POINTER_REG) + ($past(RD_BYTE) ? 16'h1 : 16'h2))
    else $error("bad pointer step");
  win_map_a: assert property (RD_TO_WINDOW ==
    (RD_BYTE_POINTER[15] && PROGRAM_WINDOW_ENABLE)) else $error("bad window");
  byte_load_a: assert property (WREG_OP && WREG_BYTE && !SIGN_EXTEND_OP
    && !ZERO_EXTEND_OP |=> WREG_NEW[15:8] == $past(WREG_OLD[15:8]))
    else $error("byte load changed high byte");
  zero_ext_a: assert property (WREG_OP && ZERO_EXTEND_OP |=>
    WREG_NEW[15:8] == 8'h00) else $error("zero extend kept high byte");
  sfr_only_a: assert property (SFR_WR_EN |->
    WR_BYTE_POINTER <= 16'h07ff) else $error("control write out of region");
endmodule
bind msam_top msam_monitor i_mon (.*);

//--- sim/msam_far_model.sv
// far side model: control register file and program window data
// assumes msam_top strobes; data held request cycle and the one after
`timescale 1ns/100ps
module msam_far_model (
  input wire CLOCK, RSTN, SFR_RD_EN, SFR_WR_EN, RD_REQ, RD_TO_WINDOW,
  input wire [9:0] SFR_RD_IDX, SFR_WR_IDX,
  input wire [15:0] SFR_WR_DATA,
  input wire [1:0] SFR_WR_LANE,
  output logic [15:0] SFR_RD_DATA, WIN_DATA,
  output logic SFR_RD_HIT
);
  logic [15:0] regs [0:15];
  logic [15:0] held_r;
  logic hit_r, win_r;
  wire hit_now = SFR_RD_EN && SFR_RD_IDX < 10'h10;
  // only 16 registers exist; the rest of the region is unused
  assign SFR_RD_HIT = hit_now || hit_r;
  assign SFR_RD_DATA = hit_now ? regs[SFR_RD_IDX[3:0]] : held_r;
  // window data goes to a changing pattern when not asked for
  assign WIN_DATA = (RD_REQ && RD_TO_WINDOW) || win_r ? 16'hc0de : ~held_r;
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      hit_r <= 1'b0;
      win_r <= 1'b0;
      held_r <= 16'h5a5a;
    end else begin
      hit_r <= hit_now;
      win_r <= RD_REQ && RD_TO_WINDOW;
      held_r <= hit_now ? SFR_RD_DATA : ~held_r;
      if (SFR_WR_EN && SFR_WR_LANE[0])
        regs[SFR_WR_IDX[3:0]][7:0] <= SFR_WR_DATA[7:0];
      if (SFR_WR_EN && SFR_WR_LANE[1])
        regs[SFR_WR_IDX[3:0]][15:8] <= SFR_WR_DATA[15:8];
    end
  end
endmodule

//--- sim/tb.sv
// testbench for msam_top with far side model and bound checker
// assumes 200 MHz CLOCK, drives inputs 1 ns after each rising edge
`timescale 1ns/100ps
module tb;
  logic CLOCK=0, RSTN=0, PC_STEP=0, PC_BACK=0, PC_LOAD=0, IRQ_TAKE=0;
  logic IRQ_ALT=0, RD_REQ=0, RD_BYTE=0, RD_DIRECT13=0, RD_DIRECT16=0;
  logic RD_POST_INC=1, WR_REQ=0, WR_BYTE=0, PROGRAM_WINDOW_ENABLE=0;
  logic WREG_OP=0, WREG_BYTE=0, SIGN_EXTEND_OP=0, ZERO_EXTEND_OP=0;
  logic [22:0] PC_LOAD_VAL=0, PROG_PC;
  logic [6:0] IRQ_NUM=0;
  logic [23:0] PROG_ADDR, PROG_WORD=24'h7e1234;
  logic [12:0] RD_NEAR_ADDR=0;
  logic [15:0] RD_ABS_ADDR=0, SOURCE_POINTER_REG=0, WR_BYTE_POINTER=0;
  logic [15:0] WR_DATA=0, WREG_OLD=0, WREG_SRC=0, RD_DATA, SRC_PTR_NEXT;
  logic [15:0] RD_BYTE_POINTER, SFR_RD_DATA, WIN_DATA, SFR_WR_DATA;
  logic [15:0] WREG_NEW, PROG_HALF;
  logic [9:0] SFR_RD_IDX, SFR_WR_IDX;
  logic [1:0] SFR_WR_LANE;
  logic PROG_IN_VEC, RD_VALID, RD_TO_WINDOW, SFR_RD_EN, SFR_RD_HIT;
  logic SFR_WR_EN, ADDR_ERR_TRAP, ADDR_ERR_RD, ADDR_ERR_WR;
  int err_total=0, n_tests=0, cyc=0;
  msam_top i_dut (.*);
  msam_far_model i_far (.*);
  always #2.5 CLOCK = ~CLOCK;
  ////////////////////////////////////////
  task chk(input logic [23:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tick; @(posedge CLOCK); #1; endtask
  task rd(input logic b, input logic [15:0] p, exp);
    RD_REQ=1; RD_BYTE=b; SOURCE_POINTER_REG=p; tick; RD_REQ=0;
    chk(RD_VALID, 1);
    chk(SRC_PTR_NEXT, p + (b ? 16'h1 : 16'h2));
    // read data lands one edge after the valid pulse
    tick;
    chk(RD_DATA, exp);
  endtask
  task wr(input logic b, input logic [15:0] p, d);
    tick;
    WR_REQ=1; WR_BYTE=b; WR_BYTE_POINTER=p; WR_DATA=d; tick; WR_REQ=0;
  endtask
  ////////////////////////////////////////
  task t_prog;
    chk(PROG_PC, 0);
    chk(PROG_HALF, 16'h1234);
    chk(PROG_ADDR, 24'h000000);
    PC_STEP=1; tick; tick; PC_STEP=0; chk(PROG_PC, 4);
    PC_BACK=1; tick; PC_BACK=0; chk(PROG_PC, 2);
    PC_LOAD=1; PC_LOAD_VAL=23'h103; tick; chk(PROG_PC, 23'h102);
    chk(PROG_IN_VEC, 1);
    PC_LOAD_VAL=23'h200; tick; PC_LOAD=0; chk(PROG_IN_VEC, 0);
    IRQ_TAKE=1; tick; chk(PROG_PC, 4);
    IRQ_ALT=1; IRQ_NUM=7'h01; tick; IRQ_TAKE=0;
    chk(PROG_PC, 23'h102);
    IRQ_ALT=0; IRQ_NUM=7'h00;
  endtask
  task t_ram;
    wr(0, 16'h0800, 16'hbeef);
    wr(1, 16'h0801, 16'h1212);
    rd(0, 16'h0800, 16'h12ef);
    rd(1, 16'h0801, 16'h0012);
  endtask
  task t_mis;
    wr(0, 16'h0801, 16'h5555); chk(ADDR_ERR_WR, 1);
    chk(ADDR_ERR_TRAP, 1);
    rd(0, 16'h0800, 16'h12ef);
    RD_REQ=1; RD_BYTE=0; SOURCE_POINTER_REG=16'h0803; tick; RD_REQ=0;
    chk(ADDR_ERR_RD, 1);
    chk(ADDR_ERR_TRAP, 1);
    tick;
  endtask
  task t_map;
    rd(0, 16'h7800, 0);
    rd(0, 16'h8000, 0);
    PROGRAM_WINDOW_ENABLE=1; rd(0, 16'h8000, 16'hc0de);
    PROGRAM_WINDOW_ENABLE=0;
    wr(0, 16'h0004, 16'h1357);
    wr(1, 16'h0005, 16'h9a9a);
    rd(0, 16'h0004, 16'h9a57);
    rd(0, 16'h0100, 0);
    RD_DIRECT13=1; RD_NEAR_ADDR=13'h1ffe; tick;
    chk(RD_BYTE_POINTER, 16'h1ffe);
    RD_DIRECT13=0; RD_DIRECT16=1; RD_ABS_ADDR=16'hfffe; tick;
    chk(RD_BYTE_POINTER, 16'hfffe);
    RD_DIRECT16=0;
  endtask
  task t_wreg;
    WREG_OP=1; WREG_BYTE=1; WREG_OLD=16'habcd; WREG_SRC=16'h0012; tick;
    chk(WREG_NEW, 16'hab12);
    SIGN_EXTEND_OP=1; WREG_SRC=16'h0080; tick;
    chk(WREG_NEW, 16'hff80);
    SIGN_EXTEND_OP=0; ZERO_EXTEND_OP=1; WREG_OLD=16'hab80; tick;
    chk(WREG_NEW, 16'h0080);
    ZERO_EXTEND_OP=0; WREG_OP=0;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge CLOCK);
    #1 RSTN=1;
    t_prog;
    t_ram;
    t_mis;
    t_map;
    t_wreg;
    end_of_test;
  end
endmodule
